// ===== cod_pkg.sv
package cod_pkg;

  // opcode of the register-to-register add, source field first
  localparam logic [7:0]  COD_OPC_ADD   = 8'h04;
  // upper nibble that turns an 8-bit register field into a working register
  localparam logic [3:0]  COD_ESC_NIB   = 4'he;
  localparam logic [3:0]  COD_NIB_ZERO  = 4'h0;
  localparam logic [7:0]  COD_BYTE_ZERO = 8'h00;
  localparam logic [11:0] COD_RA_ZERO   = 12'h000;
  localparam logic [15:0] COD_W16_ZERO  = 16'h0000;
  localparam logic [7:0]  COD_BIT_ONE   = 8'h01;

  // field widths of the bit, byte, extended address and word operand fields
  localparam int COD_BIT_W  = 3;
  localparam int COD_BYTE_W = 8;
  localparam int COD_EXT_W  = 12;
  localparam int COD_WORD_W = 16;

  // operand classes presented on the decode port
  typedef enum logic [3:0] {
    COD_CLS_REG8,
    COD_CLS_BIT,
    COD_CLS_POL,
    COD_CLS_IMM,
    COD_CLS_EXT12,
    COD_CLS_DIRECT,
    COD_CLS_PAIR,
    COD_CLS_WPAIR,
    COD_CLS_REL,
    COD_CLS_IDX,
    COD_CLS_VEC,
    COD_CLS_INDWR
  } cod_cls_t;

  // add instruction sequencer
  typedef enum logic [2:0] {
    COD_ST_OPC,
    COD_ST_F1,
    COD_ST_F2,
    COD_ST_RA,
    COD_ST_RB,
    COD_ST_RC
  } cod_state_t;

endpackage

// ===== cod_operand_decoder.sv
`timescale 1ns/1ps
module cod_operand_decoder (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // working register group base
  input  wire logic [7:0]               working_group_base,
  // instruction byte stream from fetch
  input  wire logic                     byte_valid,
  input  wire logic [7:0]               byte_data,
  output logic                          byte_ready,
  // register file port for the add
  output logic                          rf_rd_req,
  output logic [11:0]                   rf_rd_addr,
  input  wire logic [7:0]               rf_rd_data,
  output logic                          rf_wr_en,
  output logic [11:0]                   rf_wr_addr,
  output logic [7:0]                    rf_wr_data,
  // add status
  output logic                          add_done,
  output logic                          bad_opcode,
  // operand decode port
  input  wire logic                     dec_req,
  input  wire cod_pkg::cod_cls_t        dec_cls,
  input  wire logic [15:0]              dec_raw,
  input  wire logic [15:0]              dec_base,
  output logic                          dec_busy,
  output logic                          dec_done,
  output logic                          dec_legal,
  output logic [15:0]                   dec_value,
  output logic [7:0]                    dec_mask,
  // register file read port for indirect operands
  output logic                          ind_rd_req,
  output logic [11:0]                   ind_rd_addr,
  input  wire logic [7:0]               ind_rd_data
);
  import cod_pkg::*;

  typedef struct packed {
    cod_state_t  st;
    logic        src_first;
    logic [11:0] src_a;
    logic [11:0] dst_a;
    logic [7:0]  src_v;
    logic        byte_ready;
    logic        rd_req;
    logic [11:0] rd_addr;
    logic        wr_en;
    logic [11:0] wr_addr;
    logic [7:0]  wr_data;
    logic        add_done;
    logic        bad_opc;
    logic        ind_req;
    logic        ind_wait;
    logic [11:0] ind_addr;
    logic        dec_busy;
    logic        dec_done;
    logic        dec_legal;
    logic [15:0] dec_value;
    logic [7:0]  dec_mask;
  } cod_regs_t;

  cod_regs_t s_r;
  cod_regs_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // address helpers

  // working register n inside the group picked by the base register
  function automatic logic [11:0] cod_work_addr(input logic [7:0] base,
                                                input logic [3:0] n);
    cod_work_addr = {base[3:0], base[7:4], n};
  endfunction

  // 8-bit field: plain location or escaped working register
  function automatic logic [11:0] cod_reg8_addr(input logic [7:0] base,
                                                input logic [7:0] f);
    if (f[7:4] == COD_ESC_NIB) begin
      cod_reg8_addr = cod_work_addr(base, f[3:0]);
    end else begin
      cod_reg8_addr = {COD_NIB_ZERO, f};
    end
  endfunction

  // object code order per opcode; only the add is decoded here
  function automatic logic cod_src_first(input logic [7:0] opc);
    cod_src_first = (opc == COD_OPC_ADD);
  endfunction

  function automatic logic [15:0] cod_sext(input logic [7:0] d);
    cod_sext = {{COD_BYTE_W{d[7]}}, d};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic        byte_take;
  logic        dec_take;
  logic [11:0] field_addr;

  always_comb begin
    s_nxt       = s_r;
    byte_take   = byte_valid && s_r.byte_ready;
    dec_take    = dec_req && !s_r.dec_busy;
    field_addr  = cod_reg8_addr(working_group_base, byte_data);
    s_nxt.rd_req   = 1'b0;
    s_nxt.wr_en    = 1'b0;
    s_nxt.add_done = 1'b0;
    s_nxt.bad_opc  = 1'b0;

    case (s_r.st)
      COD_ST_OPC: begin
        if (byte_take) begin
          if (byte_data == COD_OPC_ADD) begin
            s_nxt.src_first = cod_src_first(byte_data);
            s_nxt.st        = COD_ST_F1;
          end else begin
            // unknown opcodes are dropped; the stream is realigned on the next byte
            s_nxt.bad_opc = 1'b1;
          end
        end
      end
      COD_ST_F1: begin
        if (byte_take) begin
          if (s_r.src_first) begin
            s_nxt.src_a = field_addr;
          end else begin
            s_nxt.dst_a = field_addr;
          end
          s_nxt.st = COD_ST_F2;
        end
      end
      COD_ST_F2: begin
        if (byte_take) begin
          if (s_r.src_first) begin
            s_nxt.dst_a = field_addr;
          end else begin
            s_nxt.src_a = field_addr;
          end
          s_nxt.byte_ready = 1'b0;
          s_nxt.rd_req     = 1'b1;
          s_nxt.rd_addr    = s_r.src_first ? s_r.src_a : field_addr;
          s_nxt.st         = COD_ST_RA;
        end
      end
      COD_ST_RA: begin
        // second read issued back to back; data returns one cycle after each
        s_nxt.rd_req  = 1'b1;
        s_nxt.rd_addr = s_r.dst_a;
        s_nxt.st      = COD_ST_RB;
      end
      COD_ST_RB: begin
        s_nxt.src_v = rf_rd_data;
        s_nxt.st    = COD_ST_RC;
      end
      COD_ST_RC: begin
        s_nxt.wr_en      = 1'b1;
        s_nxt.wr_addr    = s_r.dst_a;
        s_nxt.wr_data    = rf_rd_data + s_r.src_v;
        s_nxt.add_done   = 1'b1;
        s_nxt.byte_ready = 1'b1;
        s_nxt.st         = COD_ST_OPC;
      end
      default: begin
        s_nxt.st         = COD_ST_OPC;
        s_nxt.byte_ready = 1'b1;
      end
    endcase

    // operand decode, independent of the add sequencer
    s_nxt.dec_done = 1'b0;
    s_nxt.ind_req  = 1'b0;
    s_nxt.ind_wait = s_r.ind_req;
    if (s_r.ind_wait) begin
      s_nxt.dec_done  = 1'b1;
      s_nxt.dec_value = {COD_BYTE_ZERO, ind_rd_data};
      s_nxt.dec_busy  = 1'b0;
    end
    if (dec_take) begin
      s_nxt.dec_done  = 1'b1;
      s_nxt.dec_legal = 1'b1;
      s_nxt.dec_mask  = COD_BYTE_ZERO;
      s_nxt.dec_value = COD_W16_ZERO;
      case (dec_cls)
        COD_CLS_REG8: begin
          s_nxt.dec_legal = (dec_raw[15:8] == COD_BYTE_ZERO);
          s_nxt.dec_value = {COD_NIB_ZERO,
                             cod_reg8_addr(working_group_base, dec_raw[7:0])};
        end
        COD_CLS_BIT: begin
          s_nxt.dec_legal = (dec_raw[15:COD_BIT_W] == 13'h0000);
          s_nxt.dec_value = {13'h0000, dec_raw[2:0]};
          s_nxt.dec_mask  = COD_BIT_ONE << dec_raw[2:0];
        end
        COD_CLS_POL: begin
          s_nxt.dec_legal = (dec_raw[15:1] == 15'h0000);
          s_nxt.dec_value = {15'h0000, dec_raw[0]};
          // the byte pattern that polarity writes into the chosen bit
          s_nxt.dec_mask  = {COD_BYTE_W{dec_raw[0]}};
        end
        COD_CLS_IMM, COD_CLS_VEC: begin
          s_nxt.dec_legal = (dec_raw[15:8] == COD_BYTE_ZERO);
          s_nxt.dec_value = {COD_BYTE_ZERO, dec_raw[7:0]};
        end
        COD_CLS_EXT12: begin
          s_nxt.dec_legal = (dec_raw[15:COD_EXT_W] == COD_NIB_ZERO);
          s_nxt.dec_value = {COD_NIB_ZERO, dec_raw[11:0]};
        end
        COD_CLS_DIRECT: begin
          s_nxt.dec_value = dec_raw;
        end
        COD_CLS_PAIR: begin
          s_nxt.dec_legal = (dec_raw[15:8] == COD_BYTE_ZERO) && !dec_raw[0];
          s_nxt.dec_value = {COD_NIB_ZERO,
                             cod_reg8_addr(working_group_base, dec_raw[7:0])};
        end
        COD_CLS_WPAIR: begin
          s_nxt.dec_legal = (dec_raw[15:4] == COD_RA_ZERO) && !dec_raw[0];
          s_nxt.dec_value = {COD_NIB_ZERO,
                             cod_work_addr(working_group_base, dec_raw[3:0])};
        end
        COD_CLS_REL, COD_CLS_IDX: begin
          // base is the next instruction address or the indexed register
          s_nxt.dec_legal = (dec_raw[15:8] == COD_BYTE_ZERO);
          s_nxt.dec_value = dec_base + cod_sext(dec_raw[7:0]);
        end
        COD_CLS_INDWR: begin
          s_nxt.dec_done  = 1'b0;
          s_nxt.dec_legal = (dec_raw[15:4] == COD_RA_ZERO);
          s_nxt.ind_req   = 1'b1;
          s_nxt.ind_addr  = cod_work_addr(working_group_base, dec_raw[3:0]);
          s_nxt.dec_busy  = 1'b1;
        end
        default: begin
          s_nxt.dec_legal = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r            <= '0;
      s_r.st         <= COD_ST_OPC;
      s_r.byte_ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign byte_ready  = s_r.byte_ready;
  assign rf_rd_req   = s_r.rd_req;
  assign rf_rd_addr  = s_r.rd_addr;
  assign rf_wr_en    = s_r.wr_en;
  assign rf_wr_addr  = s_r.wr_addr;
  assign rf_wr_data  = s_r.wr_data;
  assign add_done    = s_r.add_done;
  assign bad_opcode  = s_r.bad_opc;
  assign dec_busy    = s_r.dec_busy;
  assign dec_done    = s_r.dec_done;
  assign dec_legal   = s_r.dec_legal;
  assign dec_value   = s_r.dec_value;
  assign dec_mask    = s_r.dec_mask;
  assign ind_rd_req  = s_r.ind_req;
  assign ind_rd_addr = s_r.ind_addr;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic dec_take_d;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dec_take_d <= 1'b0;
    end else begin
      dec_take_d <= dec_take && (dec_cls != COD_CLS_INDWR);
    end
  end

  add_sum_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rf_wr_en |-> rf_wr_data == 8'($past(rf_rd_data) + $past(rf_rd_data, 2))
                 && rf_wr_addr == $past(rf_rd_addr, 2))
    else $error("add result or target wrong");

  add_seq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_r.st == COD_ST_F2 && byte_valid && byte_ready)
      |=> rf_rd_req ##1 rf_rd_req ##1 !rf_rd_req ##1 (rf_wr_en && add_done))
    else $error("add read and write sequence broken");

  escape_sel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dec_take_d && $past(dec_cls) == COD_CLS_REG8 && $past(dec_raw[7:4]) == COD_ESC_NIB)
      |-> dec_value[3:0] == $past(dec_raw[3:0])
          && dec_value[11:4] == {$past(working_group_base[3:0]),
                                 $past(working_group_base[7:4])})
    else $error("escaped working register address wrong");

  bit_onehot_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dec_take_d && $past(dec_cls) == COD_CLS_BIT)
      |-> $onehot(dec_mask) && dec_mask[$past(dec_raw[2:0])])
    else $error("bit mask wrong");

  pair_even_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dec_take_d && $past(dec_cls) == COD_CLS_PAIR && dec_legal) |-> !$past(dec_raw[0]))
    else $error("odd register pair accepted");

  wpair_even_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dec_take_d && $past(dec_cls) == COD_CLS_WPAIR && $past(dec_raw[0])) |-> !dec_legal)
    else $error("odd working pair accepted");

  rel_target_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dec_take_d && $past(dec_cls) == COD_CLS_REL)
      |-> dec_value == 16'($past(dec_base) + {{8{$past(dec_raw[7])}}, $past(dec_raw[7:0])}))
    else $error("jump displacement target wrong");

  ext_range_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dec_take_d && $past(dec_cls) == COD_CLS_EXT12) |-> dec_value == 16'($past(dec_raw[11:0])))
    else $error("extended address out of range");

  ind_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ind_rd_req |-> dec_busy ##1 !dec_done ##1 (dec_done && dec_value[7:0] == $past(ind_rd_data)))
    else $error("indirect operand not returned");

endmodule

// ===== cod_rf_model.sv
`timescale 1ns/1ps
module cod_rf_model (
  // clock
  input  wire logic        clk_sys,
  // add read and write port
  input  wire logic        rd_req,
  input  wire logic [11:0] rd_addr,
  output logic      [7:0]  rd_data,
  input  wire logic        wr_en,
  input  wire logic [11:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  // indirect read port
  input  wire logic        ind_req,
  input  wire logic [11:0] ind_addr,
  output logic      [7:0]  ind_data
);
  logic [7:0] mem [0:4095];

  initial begin
    rd_data = 8'h00;
    ind_data = 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  // data only valid the cycle after a request; idle lines toggle so a
  // decoder sampling late never sees stale data
  always @(posedge clk_sys) begin
    rd_data <= rd_req ? mem[rd_addr] : ~rd_data;
    ind_data <= ind_req ? mem[ind_addr] : ~ind_data;
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule

// ===== cpu_operand_encoding_tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected %s exp=%h got=%h", nm, exp, got); end end
module cpu_operand_encoding_tb;
  import cod_pkg::*;
  typedef struct packed {
    cod_cls_t    cls;
    logic [15:0] raw;
    logic [15:0] base;
    logic [15:0] val;
    logic        legal;
    logic        cv;
    logic [7:0]  mask;
  } cod_row_t;
  localparam int NROWS = 19;
  // working group base 8'h21 places escaped registers at 12'h12n
  localparam cod_row_t ROWS [NROWS] = '{
    '{COD_CLS_REG8,   16'h0043, 16'h0000, 16'h0043, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_REG8,   16'h00ff, 16'h0000, 16'h00ff, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_REG8,   16'h00e8, 16'h0000, 16'h0128, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_REG8,   16'h0100, 16'h0000, 16'h0000, 1'b0, 1'b0, 8'h00},
    '{COD_CLS_BIT,    16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b1, 8'h01},
    '{COD_CLS_BIT,    16'h0007, 16'h0000, 16'h0007, 1'b1, 1'b1, 8'h80},
    '{COD_CLS_POL,    16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_POL,    16'h0001, 16'h0000, 16'h0001, 1'b1, 1'b1, 8'hff},
    '{COD_CLS_IMM,    16'h00ff, 16'h0000, 16'h00ff, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_EXT12,  16'h0fff, 16'h0000, 16'h0fff, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_DIRECT, 16'hffff, 16'h0000, 16'hffff, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_DIRECT, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_PAIR,   16'h00fe, 16'h0000, 16'h00fe, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_PAIR,   16'h0043, 16'h0000, 16'h0000, 1'b0, 1'b0, 8'h00},
    '{COD_CLS_WPAIR,  16'h000e, 16'h0000, 16'h012e, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_WPAIR,  16'h0003, 16'h0000, 16'h0000, 1'b0, 1'b0, 8'h00},
    '{COD_CLS_REL,    16'h0080, 16'h1000, 16'h0f80, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_REL,    16'h007f, 16'hffff, 16'h007e, 1'b1, 1'b1, 8'h00},
    '{COD_CLS_IDX,    16'h00ff, 16'h0010, 16'h000f, 1'b1, 1'b1, 8'h00}
  };

  logic clk_sys, resetn, byte_valid, byte_ready, rf_rd_req, rf_wr_en, add_done, bad_opcode;
  logic dec_req, dec_busy, dec_done, dec_legal, ind_rd_req;
  logic [7:0] working_group_base, byte_data, rf_rd_data, rf_wr_data, dec_mask, ind_rd_data;
  logic [11:0] rf_rd_addr, rf_wr_addr, ind_rd_addr;
  logic [15:0] dec_raw, dec_base, dec_value;
  cod_cls_t dec_cls;
  int n_fail = 0;
  int num_checks = 0;
  logic hit;

  cod_operand_decoder dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .working_group_base(working_group_base), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .rf_rd_req(rf_rd_req),
    .rf_rd_addr(rf_rd_addr), .rf_rd_data(rf_rd_data), .rf_wr_en(rf_wr_en),
    .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data), .add_done(add_done),
    .bad_opcode(bad_opcode), .dec_req(dec_req), .dec_cls(dec_cls), .dec_raw(dec_raw),
    .dec_base(dec_base), .dec_busy(dec_busy), .dec_done(dec_done), .dec_legal(dec_legal),
    .dec_value(dec_value), .dec_mask(dec_mask), .ind_rd_req(ind_rd_req),
    .ind_rd_addr(ind_rd_addr), .ind_rd_data(ind_rd_data));

  cod_rf_model model_u (.clk_sys(clk_sys), .rd_req(rf_rd_req), .rd_addr(rf_rd_addr),
    .rd_data(rf_rd_data), .wr_en(rf_wr_en), .wr_addr(rf_wr_addr), .wr_data(rf_wr_data),
    .ind_req(ind_rd_req), .ind_addr(ind_rd_addr), .ind_data(ind_rd_data));

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // valid stays up across back-to-back bytes, dropped once after the last
  task automatic send_bytes(input logic [7:0] b [3], input int n);
    int k;
    int i;
    for (k = 0; k < n; k++) begin
      byte_valid <= 1'b1;
      byte_data <= b[k];
      for (i = 0; i < 20; i++) begin
        @(posedge clk_sys);
        if (byte_ready === 1'b1) break;
      end
    end
    byte_valid <= 1'b0;
  endtask

  // polls a one-cycle pulse just after each edge, bounded
  task automatic poll(input int w, output logic f);
    int i;
    f = 1'b0;
    for (i = 0; i < 10 && f !== 1'b1; i++) begin
      #1;
      f = (w == 0) ? add_done : (w == 1) ? dec_done : bad_opcode;
      if (f !== 1'b1) @(posedge clk_sys);
    end
  endtask

  task automatic decode(input cod_cls_t c, input logic [15:0] r, bs, input int hold);
    dec_req <= 1'b1;
    dec_cls <= c;
    dec_raw <= r;
    dec_base <= bs;
    repeat (hold) @(posedge clk_sys);
    dec_req <= 1'b0;
    poll(1, hit);
  endtask

  task automatic run_add(input logic [7:0] src, dst, input logic [11:0] ea, input logic [7:0] ed);
    @(posedge clk_sys);
    send_bytes('{8'h04, src, dst}, 3);
    poll(0, hit);
    `CHK("add_done", 1'b1, hit)
    `CHK("rf_wr_addr", ea, rf_wr_addr)
    `CHK("rf_wr_data", ed, rf_wr_data)
    @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    working_group_base = 8'h21;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    dec_req = 1'b0;
    dec_cls = COD_CLS_REG8;
    dec_raw = 16'h0000;
    dec_base = 16'h0000;
    repeat (5) @(posedge clk_sys);
    `CHK("byte_ready in reset", 1'b1, byte_ready)
    `CHK("rf_wr_en in reset", 1'b0, rf_wr_en)
    `CHK("dec_done in reset", 1'b0, dec_done)
    resetn <= 1'b1;
    model_u.mem[12'h008] = 8'h20;
    model_u.mem[12'h043] = 8'hf0;
    model_u.mem[12'h128] = 8'h05;
    model_u.mem[12'h125] = 8'h3c;
    for (int r = 0; r < NROWS; r++) begin
      @(posedge clk_sys);
      decode(ROWS[r].cls, ROWS[r].raw, ROWS[r].base, 1);
      `CHK("dec_done", 1'b1, hit)
      `CHK("dec_legal", ROWS[r].legal, dec_legal)
      `CHK("dec_mask", ROWS[r].mask, dec_mask)
      if (ROWS[r].cv) `CHK("dec_value", ROWS[r].val, dec_value)
    end
    @(posedge clk_sys);
    decode(COD_CLS_VEC, 16'h00ff, 16'h0000, 1);
    `CHK("vector value", 16'h00ff, dec_value)
    // second cycle of the request lands while busy and must be dropped
    @(posedge clk_sys);
    decode(COD_CLS_INDWR, 16'h0005, 16'h0000, 2);
    `CHK("indirect done", 1'b1, hit)
    `CHK("indirect value", 16'h003c, dec_value)
    `CHK("indirect legal", 1'b1, dec_legal)
    `CHK("indirect busy", 1'b0, dec_busy)
    `CHK("indirect address", 12'h125, ind_rd_addr)
    @(posedge clk_sys);
    poll(1, hit);
    `CHK("extra done while busy", 1'b0, hit)
    // sum wraps modulo 256 into the destination
    run_add(8'h08, 8'h43, 12'h043, 8'h10);
    run_add(8'he8, 8'h43, 12'h043, 8'h15);
    send_bytes('{8'h05, 8'h00, 8'h00}, 1);
    poll(2, hit);
    `CHK("bad_opcode", 1'b1, hit)
    // stream must resync on the byte after the dropped opcode
    run_add(8'h08, 8'h43, 12'h043, 8'h35);
    // reset cut in after the last byte: the pending add must never write
    @(posedge clk_sys);
    send_bytes('{8'h04, 8'h08, 8'h43}, 3);
    resetn <= 1'b0;
    @(posedge clk_sys);
    `CHK("byte_ready after cut", 1'b1, byte_ready)
    `CHK("rf_rd_req after cut", 1'b0, rf_rd_req)
    resetn <= 1'b1;
    poll(0, hit);
    `CHK("add_done after cut", 1'b0, hit)
    run_add(8'h08, 8'h43, 12'h043, 8'h55);
    stop_test();
  end

  initial begin
    #20000;
    n_fail++;
    stop_test();
  end
endmodule
